/* pap_pkg.sv */
// package: register map, field layout and carriers for page access protection
package pap_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] FAULT_ADDR_OFS   = 8'h00;
    localparam logic [7:0] FAULT_STATUS_OFS = 8'h04;
    localparam logic [7:0] FAULT_CMD_OFS    = 8'h08;
    localparam logic [7:0] PAGE_ATTR_OFS    = 8'h0C;
    localparam logic [7:0] IRQ_STATUS_OFS   = 8'h10;
    localparam logic [7:0] IRQ_ENABLE_OFS   = 8'h14;
    localparam logic [7:0] IRQ_CLEAR_OFS    = 8'h18;

    // page attribute field positions
    localparam int ATTR_AID_LSB   = 10;
    localparam int ATTR_AID_MSB   = 15;
    localparam int ATTR_EXT_BIT   = 9;
    localparam int ATTR_SR_BIT    = 5;
    localparam int ATTR_SW_BIT    = 4;
    localparam int ATTR_SX_BIT    = 3;
    localparam int ATTR_UR_BIT    = 2;
    localparam int ATTR_UW_BIT    = 1;
    localparam int ATTR_UX_BIT    = 0;
    localparam int NUM_AID        = 6;
    localparam logic [3:0] OUTSIDE_ID_MIN = 4'h6;

    // writable bits and reset value of the page attribute register
    localparam logic [31:0] ATTR_WMASK = 32'h0000FEFF;
    localparam logic [31:0] ATTR_RESET = 32'h0000FEF6;

    // fault status field positions
    localparam int FSTAT_ID_LSB = 9;
    localparam int FSTAT_ID_MSB = 12;
    localparam int FCMD_CLR_BIT = 0;

    // interrupt status bits
    localparam int IRQ_FAULT_BIT = 0;
    localparam int IRQ_OVER_BIT  = 1;
    localparam int IRQ_W         = 2;

    localparam logic [31:0] FAULT_ADDR_RESET = 32'h00000000;
    localparam logic [31:0] SLVERR_RDATA     = 32'h00000000;

    // access kind carried by a request
    typedef enum logic [1:0] {
        PAP_ACC_READ,
        PAP_ACC_WRITE,
        PAP_ACC_EXEC
    } pap_acc_t;

    // request presented for checking
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [3:0]  priv_id;
        logic        supervisor;
        pap_acc_t    kind;
    } pap_req_t;

    // apb slave outputs
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pap_apb_rsp_t;

    // whole module state
    typedef struct packed {
        logic [31:0]        attr;
        logic [31:0]        fault_addr;
        logic [3:0]         fault_id;
        logic [5:0]         fault_flags;
        logic [IRQ_W-1:0]   irq_status;
        logic [IRQ_W-1:0]   irq_enable;
        logic               irq;
        logic               granted;
        logic               denied;
        pap_apb_rsp_t       apb;
    } pap_state_t;

endpackage

/* pap_page_protect.sv */
// page access protection checker with apb register file
// Functional notes
// (RULE1) clear bit one clears fault address, status
// (RULE2) clear bit zero leaves fault state alone
// (RULE3) allowed-id bit zero refuses that id
// (RULE4) outside bit governs ids six and up
// (RULE5) software writes ones to bits 7-6
// (RULE6) bit 5 gates supervisor reads
// (RULE7) bit 4 gates supervisor writes
// (RULE8) bit 3 gates supervisor execute
// (RULE9) bit 2 gates user reads
// (RULE10) bit 1 gates user writes
// (RULE11) bit 0 gates user execute
// (RULE12) violation captures full fault address
// (RULE13) violation records privilege id in status
// (RULE14) one status flag per violation type
// (RULE15) requests carry id, level and kind
`timescale 1ns/100ps
`default_nettype none

module pap_page_protect
(
    input  wire logic                 i_clock,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [7:0]           i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output var  logic [31:0]          o_prdata,
    output var  logic                 o_pready,
    output var  logic                 o_pslverr,
    input  wire pap_pkg::pap_req_t    i_req,
    output var  logic                 o_granted,
    output var  logic                 o_denied,
    output var  logic                 o_irq
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------

    // permission bit that applies to one level and kind
    function automatic logic perm_of(input logic [31:0] attr,
                                     input logic supervisor,
                                     input pap_pkg::pap_acc_t kind);
        logic p;
        p = 1'b0;
        case (kind)
            pap_pkg::PAP_ACC_READ:  p = supervisor ? attr[pap_pkg::ATTR_SR_BIT]
                                                   : attr[pap_pkg::ATTR_UR_BIT];
            pap_pkg::PAP_ACC_WRITE: p = supervisor ? attr[pap_pkg::ATTR_SW_BIT]
                                                   : attr[pap_pkg::ATTR_UW_BIT];
            pap_pkg::PAP_ACC_EXEC:  p = supervisor ? attr[pap_pkg::ATTR_SX_BIT]
                                                   : attr[pap_pkg::ATTR_UX_BIT];
            default:                p = 1'b0;
        endcase
        return p;
    endfunction

    // one-hot fault flag for a level and kind, bit 5 supervisor read down to user exec
    function automatic logic [5:0] flag_of(input logic supervisor,
                                           input pap_pkg::pap_acc_t kind);
        logic [5:0] f;
        f = 6'h00;
        case (kind)
            pap_pkg::PAP_ACC_READ:  f = supervisor ? 6'h20 : 6'h04;
            pap_pkg::PAP_ACC_WRITE: f = supervisor ? 6'h10 : 6'h02;
            pap_pkg::PAP_ACC_EXEC:  f = supervisor ? 6'h08 : 6'h01;
            default:                f = 6'h00;
        endcase
        return f;
    endfunction

    // ----------------------------------------------------------------
    // id admission
    // ----------------------------------------------------------------

    localparam int IRQ_W_L = pap_pkg::IRQ_W;

    pap_pkg::pap_state_t         r_reg;
    pap_pkg::pap_state_t         r_next;
    logic [pap_pkg::NUM_AID-1:0] id_hit;
    logic                        id_ok;
    logic                        perm_ok;
    logic                        violation;

    // one decoder per allowed-id bit
    // (RULE3) per-id admission
    genvar g;
    generate
        for (g = 0; g < pap_pkg::NUM_AID; g++)
        begin : g_aid
            assign id_hit[g] = (i_req.priv_id == 4'(g))
                               && r_reg.attr[pap_pkg::ATTR_AID_LSB + g];
        end
    endgenerate

    // (RULE4) outside ids use one bit
    assign id_ok = (i_req.priv_id >= pap_pkg::OUTSIDE_ID_MIN)
                   ? r_reg.attr[pap_pkg::ATTR_EXT_BIT]
                   : (|id_hit);

    // (RULE6) (RULE7) (RULE8) (RULE9) (RULE10) (RULE11) permission pick
    assign perm_ok = perm_of(r_reg.attr, i_req.supervisor, i_req.kind);

    // (RULE15) request fields drive the check
    assign violation = i_req.valid && !(id_ok && perm_ok);

    // ----------------------------------------------------------------
    // state update
    // ----------------------------------------------------------------

    logic apb_access;
    logic apb_wr;
    logic apb_rd;
    logic addr_hit;
    logic clr_cmd;

    assign apb_access = i_psel && i_penable;
    // writes commit only at the edge that completes the transfer
    assign apb_wr     = apb_access && i_pwrite && r_reg.apb.pready;
    assign apb_rd     = apb_access && !i_pwrite;
    assign addr_hit   = (i_paddr == pap_pkg::FAULT_ADDR_OFS)
                        || (i_paddr == pap_pkg::FAULT_STATUS_OFS)
                        || (i_paddr == pap_pkg::FAULT_CMD_OFS)
                        || (i_paddr == pap_pkg::PAGE_ATTR_OFS)
                        || (i_paddr == pap_pkg::IRQ_STATUS_OFS)
                        || (i_paddr == pap_pkg::IRQ_ENABLE_OFS)
                        || (i_paddr == pap_pkg::IRQ_CLEAR_OFS);
    // (RULE1) (RULE2) only a written one clears
    assign clr_cmd    = apb_wr && (i_paddr == pap_pkg::FAULT_CMD_OFS)
                        && i_pwdata[pap_pkg::FCMD_CLR_BIT];

    // next-state logic for registers, fault capture and bus answer
    always_comb
    begin
        logic [IRQ_W_L-1:0] ev;
        ev     = '0;
        r_next = r_reg;

        // attribute write keeps read-only bits at their fixed values
        if (apb_wr && (i_paddr == pap_pkg::PAGE_ATTR_OFS))
        begin
            r_next.attr = (i_pwdata & pap_pkg::ATTR_WMASK)
                          | (pap_pkg::ATTR_RESET & ~pap_pkg::ATTR_WMASK);
        end
        if (apb_wr && (i_paddr == pap_pkg::IRQ_ENABLE_OFS))
        begin
            r_next.irq_enable = i_pwdata[IRQ_W_L-1:0];
        end

        // (RULE1) clear fault address and status
        if (clr_cmd)
        begin
            r_next.fault_addr  = pap_pkg::FAULT_ADDR_RESET;
            r_next.fault_id    = 4'h0;
            r_next.fault_flags = 6'h00;
        end

        // (RULE12) (RULE13) (RULE14) capture, set wins over clear
        if (violation)
        begin
            if ((r_reg.fault_flags == 6'h00) || clr_cmd)
            begin
                r_next.fault_addr  = i_req.addr;
                r_next.fault_id    = i_req.priv_id;
                r_next.fault_flags = flag_of(i_req.supervisor, i_req.kind);
                ev[pap_pkg::IRQ_FAULT_BIT] = 1'b1;
            end
            else
            begin
                r_next.fault_flags = r_reg.fault_flags
                                     | flag_of(i_req.supervisor, i_req.kind);
                ev[pap_pkg::IRQ_OVER_BIT] = 1'b1;
            end
        end

        // sticky interrupt status, event set wins over write-one clear
        if (apb_wr && (i_paddr == pap_pkg::IRQ_CLEAR_OFS))
        begin
            r_next.irq_status = r_reg.irq_status & ~i_pwdata[IRQ_W_L-1:0];
        end
        r_next.irq_status = r_next.irq_status | ev;
        r_next.irq        = |(r_next.irq_status & r_next.irq_enable);

        r_next.granted = i_req.valid && !violation;
        r_next.denied  = violation;

        // apb answer, ready in the access cycle's next edge
        r_next.apb.pready  = apb_access && !r_reg.apb.pready;
        r_next.apb.pslverr = apb_access && !r_reg.apb.pready && !addr_hit;
        r_next.apb.prdata  = pap_pkg::SLVERR_RDATA;
        if (apb_rd && !r_reg.apb.pready)
        begin
            case (i_paddr)
                pap_pkg::FAULT_ADDR_OFS:   r_next.apb.prdata = r_reg.fault_addr;
                pap_pkg::FAULT_STATUS_OFS: r_next.apb.prdata =
                    {19'h00000, r_reg.fault_id, 3'h0, r_reg.fault_flags};
                pap_pkg::PAGE_ATTR_OFS:    r_next.apb.prdata = r_reg.attr;
                pap_pkg::IRQ_STATUS_OFS:   r_next.apb.prdata =
                    {30'h00000000, r_reg.irq_status};
                pap_pkg::IRQ_ENABLE_OFS:   r_next.apb.prdata =
                    {30'h00000000, r_reg.irq_enable};
                default:                   r_next.apb.prdata = pap_pkg::SLVERR_RDATA;
            endcase
        end
    end

    // state register
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            r_reg            <= '0;
            r_reg.attr       <= pap_pkg::ATTR_RESET;
            r_reg.fault_addr <= pap_pkg::FAULT_ADDR_RESET;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // outputs straight from flip-flops
    assign o_prdata  = r_reg.apb.prdata;
    assign o_pready  = r_reg.apb.pready;
    assign o_pslverr = r_reg.apb.pslverr;
    assign o_granted = r_reg.granted;
    assign o_denied  = r_reg.denied;
    assign o_irq     = r_reg.irq;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------

    // (RULE1) clear empties status
    property p_clear_empties;
        @(posedge i_clock) disable iff (!i_rst_n)
        (clr_cmd && !violation) |=> (r_reg.fault_flags == 6'h00)
                                    && (r_reg.fault_addr == 32'h00000000);
    endproperty
    a_clear_empties: assert property (p_clear_empties) // RULE1
        else $error("fault clear did not empty fault state");

    // (RULE2) zero write keeps state
    property p_zero_keeps;
        @(posedge i_clock) disable iff (!i_rst_n)
        (apb_wr && (i_paddr == pap_pkg::FAULT_CMD_OFS) && !i_pwdata[0] && !violation)
        |=> $stable(r_reg.fault_addr) && $stable(r_reg.fault_flags);
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) // RULE2
        else $error("zero write to clear bit changed fault state");

    // (RULE3) disallowed id refused
    property p_id_refused;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_req.valid && (i_req.priv_id < 4'h6)
         && !r_reg.attr[pap_pkg::ATTR_AID_LSB + 32'(i_req.priv_id)]) |=> o_denied;
    endproperty
    a_id_refused: assert property (p_id_refused) // RULE3
        else $error("request with disallowed id was not refused");

    // (RULE4) outside ids refused
    property p_ext_refused;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_req.valid && (i_req.priv_id >= 4'h6) && !r_reg.attr[9]) |=> o_denied;
    endproperty
    a_ext_refused: assert property (p_ext_refused) // RULE4
        else $error("outside id was not refused");

    // (RULE6) supervisor read gate
    property p_sup_read;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_req.valid && i_req.supervisor && (i_req.kind == pap_pkg::PAP_ACC_READ)
         && !r_reg.attr[5]) |=> o_denied && !o_granted;
    endproperty
    a_sup_read: assert property (p_sup_read) // RULE6
        else $error("supervisor read passed without permission");

    // (RULE10) user write gate
    property p_user_write;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_req.valid && !i_req.supervisor && (i_req.kind == pap_pkg::PAP_ACC_WRITE)
         && !r_reg.attr[1]) |=> o_denied;
    endproperty
    a_user_write: assert property (p_user_write) // RULE10
        else $error("user write passed without permission");

    // (RULE12) address captured on first fault
    property p_addr_capture;
        @(posedge i_clock) disable iff (!i_rst_n)
        (violation && (r_reg.fault_flags == 6'h00)) |=> (r_reg.fault_addr == $past(i_req.addr));
    endproperty
    a_addr_capture: assert property (p_addr_capture) // RULE12
        else $error("fault address not captured");

    // (RULE13) id recorded
    property p_id_capture;
        @(posedge i_clock) disable iff (!i_rst_n)
        (violation && (r_reg.fault_flags == 6'h00)) |=> (r_reg.fault_id == $past(i_req.priv_id));
    endproperty
    a_id_capture: assert property (p_id_capture) // RULE13
        else $error("faulting id not recorded");

    // (RULE14) a violation leaves a fault flag and an interrupt status bit set
    property p_flag_set;
        @(posedge i_clock) disable iff (!i_rst_n)
        violation |=> (r_reg.fault_flags != 6'h00)
                      && (r_reg.irq_status != 2'b00);
    endproperty
    a_flag_set: assert property (p_flag_set) // RULE14
        else $error("violation left no status flag");

    // (RULE7) supervisor write gate
    property p_sup_write;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_req.valid && i_req.supervisor && (i_req.kind == pap_pkg::PAP_ACC_WRITE)
         && !r_reg.attr[4]) |=> o_denied && !o_granted;
    endproperty
    a_sup_write: assert property (p_sup_write) // RULE7
        else $error("supervisor write passed without permission");

    // (RULE8) supervisor execute gate
    property p_sup_exec;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_req.valid && i_req.supervisor && (i_req.kind == pap_pkg::PAP_ACC_EXEC)
         && !r_reg.attr[3]) |=> o_denied && !o_granted;
    endproperty
    a_sup_exec: assert property (p_sup_exec) // RULE8
        else $error("supervisor execute passed without permission");

    // (RULE9) user read gate
    property p_user_read;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_req.valid && !i_req.supervisor && (i_req.kind == pap_pkg::PAP_ACC_READ)
         && !r_reg.attr[2]) |=> o_denied && !o_granted;
    endproperty
    a_user_read: assert property (p_user_read) // RULE9
        else $error("user read passed without permission");

    // (RULE11) user execute gate
    property p_user_exec;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_req.valid && !i_req.supervisor && (i_req.kind == pap_pkg::PAP_ACC_EXEC)
         && !r_reg.attr[0]) |=> o_denied && !o_granted;
    endproperty
    a_user_exec: assert property (p_user_exec) // RULE11
        else $error("user execute passed without permission");

endmodule

`default_nettype wire

/* pap_requestor.sv */
// partner model: bus requestor presenting accesses for protection checking
`timescale 1ns/100ps
`default_nettype none

module pap_requestor
(
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    input  wire logic              i_issue,
    input  wire logic [31:0]       i_addr,
    input  wire logic [3:0]        i_id,
    input  wire logic              i_sup,
    input  wire logic [1:0]        i_kind,
    output var  pap_pkg::pap_req_t o_req
);
    // ----------------------------------------
    // request launch
    // ----------------------------------------
    // one request per issue; idle fields are scrambled so stale values never pass
    // full request fields
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_req <= '0;
        else if (i_issue)
            o_req <= {1'h1, i_addr, i_id, i_sup, i_kind};
        else
            o_req <= {1'h0, ~o_req.addr, ~o_req.priv_id, ~o_req.supervisor, ~o_req.kind};
    end
endmodule

`default_nettype wire

/* tb_page_access_protection.sv */
// testbench: page access protection checker with apb registers
`timescale 1ns/100ps
`default_nettype none

module tb_page_access_protection;
    logic              clock;
    logic              rst_n;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    pap_pkg::pap_req_t req;
    logic              granted;
    logic              denied;
    logic              irq;
    logic              issue;
    logic [31:0]       r_addr;
    logic [3:0]        r_id;
    logic              r_sup;
    logic [1:0]        r_kind;
    logic [31:0]       attr_shadow;
    logic [31:0]       rd;
    logic [31:0]       fa;
    logic              err;
    int                num_errors = 0;
    int                total_checks = 0;

    // ----------------------------------------
    // instances and clock
    // ----------------------------------------
    pap_page_protect u_pap_page_protect (.i_clock(clock), .i_rst_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_req(req),
        .o_granted(granted), .o_denied(denied), .o_irq(irq));
    pap_requestor u_pap_requestor (.i_clock(clock), .i_rst_n(rst_n), .i_issue(issue),
        .i_addr(r_addr), .i_id(r_id), .i_sup(r_sup), .i_kind(r_kind), .o_req(req));

    // free running clock
    always #20 clock = ~clock;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // expected verdict: id admission and then the level and kind permission
    function automatic logic exp_grant(input logic [31:0] a, input logic [3:0] id,
                                       input logic sup, input logic [1:0] kind);
        logic adm;
        adm = (id >= 4'h6) ? a[9] : a[10 + id];
        return adm & a[(sup ? 3 : 0) + 2 - kind];
    endfunction

    task automatic tally_and_finish;
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer, held until pready is sampled high or 20 access cycles pass
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        rd = prdata;
        err = pslverr;
        check("pready", 32'h1, {31'h0, pready});
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        check(name, exp, rd);
    endtask

    task automatic wr_attr(input logic [31:0] d);
        apb(1'h1, pap_pkg::PAGE_ATTR_OFS, d);
        attr_shadow = d & pap_pkg::ATTR_WMASK;
        rd_chk("page_attribute", pap_pkg::PAGE_ATTR_OFS, attr_shadow);
    endtask

    // present one request and sample the verdict one cycle after it is taken
    task automatic do_req(input logic [3:0] id, input logic sup, input logic [1:0] kind,
                          input logic [31:0] a);
        @(posedge clock);
        issue <= 1'h1;
        r_addr <= a;
        r_id <= id;
        r_sup <= sup;
        r_kind <= kind;
        @(posedge clock);
        issue <= 1'h0;
        @(posedge clock);
        #1;
    endtask

    task automatic req_chk(input logic [3:0] id, input logic sup, input logic [1:0] kind);
        logic g;
        g = exp_grant(attr_shadow, id, sup, kind);
        do_req(id, sup, kind, $urandom);
        check("granted", {31'h0, g}, {31'h0, granted});
        check("denied", {31'h0, ~g}, {31'h0, denied});
    endtask

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    // generous bound against a hung handshake
    initial
    begin
        #800000;
        num_errors++;
        $display("mismatch watchdog expected done seen hang");
        tally_and_finish;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    // reset, registers, fault capture, interrupt, boundaries, random
    initial
    begin
        clock = 1'h0;
        rst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        issue = 1'h0;
        r_addr = 32'h0;
        r_id = 4'h0;
        r_sup = 1'h0;
        r_kind = 2'h0;
        void'($urandom(32'h1090FC04));
        repeat (4) @(posedge clock);
        rst_n <= 1'h1;
        attr_shadow = pap_pkg::ATTR_RESET;
        rd_chk("page_attribute", pap_pkg::PAGE_ATTR_OFS, pap_pkg::ATTR_RESET);
        rd_chk("fault_status", pap_pkg::FAULT_STATUS_OFS, 32'h0);
        rd_chk("irq_enable", pap_pkg::IRQ_ENABLE_OFS, 32'h0);
        rd_chk("fault_clear_command", pap_pkg::FAULT_CMD_OFS, 32'h0);
        apb(1'h0, 8'h1C, 32'h0);
        check("pslverr", 32'h1, {31'h0, err});
        check("unmapped rdata", 32'h0, rd);
        apb(1'h1, pap_pkg::IRQ_ENABLE_OFS, 32'h1);
        fa = $urandom;
        do_req(4'h3, 1'h1, 2'h2, fa);
        check("denied", 32'h1, {31'h0, denied});
        check("irq", 32'h1, {31'h0, irq});
        rd_chk("fault_address", pap_pkg::FAULT_ADDR_OFS, fa);
        rd_chk("fault_status", pap_pkg::FAULT_STATUS_OFS, 32'h00000608);
        do_req(4'h7, 1'h0, 2'h2, ~fa);
        rd_chk("fault_address", pap_pkg::FAULT_ADDR_OFS, fa);
        rd_chk("fault_status", pap_pkg::FAULT_STATUS_OFS, 32'h00000609);
        apb(1'h1, pap_pkg::FAULT_CMD_OFS, 32'hFFFFFFFE);
        rd_chk("fault_address", pap_pkg::FAULT_ADDR_OFS, fa);
        rd_chk("fault_status", pap_pkg::FAULT_STATUS_OFS, 32'h00000609);
        apb(1'h1, pap_pkg::FAULT_CMD_OFS, 32'h1);
        rd_chk("fault_address", pap_pkg::FAULT_ADDR_OFS, 32'h0);
        rd_chk("fault_status", pap_pkg::FAULT_STATUS_OFS, 32'h0);
        rd_chk("irq_status", pap_pkg::IRQ_STATUS_OFS, 32'h3);
        apb(1'h1, pap_pkg::IRQ_CLEAR_OFS, 32'h3);
        @(posedge clock);
        #1;
        check("irq", 32'h0, {31'h0, irq});
        apb(1'h1, pap_pkg::IRQ_ENABLE_OFS, 32'h0);
        do_req(4'h0, 1'h1, 2'h2, fa);
        check("irq", 32'h0, {31'h0, irq});
        rd_chk("irq_status", pap_pkg::IRQ_STATUS_OFS, 32'h1);
        wr_attr(32'h00007EFF);
        req_chk(4'h5, 1'h1, 2'h0);
        req_chk(4'h6, 1'h1, 2'h0);
        wr_attr(32'h0000FCFF);
        req_chk(4'h6, 1'h1, 2'h0);
        req_chk(4'hF, 1'h0, 2'h1);
        req_chk(4'h0, 1'h0, 2'h2);
        repeat (40)
        begin
            wr_attr($urandom | 32'h000000C0);
            for (int k = 0; k < 6; k++)
                req_chk(4'($urandom_range(15, 0)), k >= 3, 2'(k % 3));
        end
        // second reset in mid-run restores register defaults
        @(posedge clock);
        rst_n <= 1'h0;
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        rd_chk("page_attribute", pap_pkg::PAGE_ATTR_OFS, pap_pkg::ATTR_RESET);
        rd_chk("fault_address", pap_pkg::FAULT_ADDR_OFS, 32'h0);
        rd_chk("fault_status", pap_pkg::FAULT_STATUS_OFS, 32'h0);
        rd_chk("irq_status", pap_pkg::IRQ_STATUS_OFS, 32'h0);
        check("irq", 32'h0, {31'h0, irq});
        tally_and_finish;
    end
endmodule

`default_nettype wire
